// file: design/dacrc_top.sv
// Contract
// [RL1] conversion paced by external converter clock; 8 MHz gives 500 kHz
// [RL2] results are two's complement: 7ff, 000, fff, 800
// [RL3] host may convert second pair first by ordering the select level
// [RL4] host drives start strobe low at least 5 ns
// [RL5] start strobe fall puts both sample-and-holds into hold together
// [RL6] conversion starts on first clock rise after start, lasts sixteen
// [RL7] pair select captured at the converting clock edge
// [RL8] host sets pair select 250 ns before start falls
// [RL9] busy rises after start falls, falls when conversion finished
// [RL10] data bus driven only while chip select and read both low
// [RL11] first read gives first converter, next read the second
// [RL12] latest results of both pairs kept, select chooses pair read
// [RL13] returning select low rereads latest first-pair results
// [RL14] host holds read strobe low at least 30 ns
// [RL15] host avoids reads from 125 ns before to 10 ns after start
// [RL16] every read strobe toggle advances pointer, chip select ignored
// [RL17] shared bus hosts gate read strobe with chip select
// [RL18] result bits on bus most significant first
// [RL19] select low picks first inputs, high picks second inputs
// [RL20] read pointer returns to first converter on select change or store
`include "dacrc_map.svh"

module dacrc_top #(
   parameter int CODE_W = `DACRC_CODE_W,
   parameter int FIFO_DEPTH = `DACRC_FIFO_DEPTH,
   parameter int CLK_LOST_CYC = `DACRC_CLK_LOST_CYC
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic conv_clk,
   input wire logic conversion_start_n,
   input wire logic channel_pair_select,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire dacrc_pkg::dacrc_code_t ain_a0,
   input wire dacrc_pkg::dacrc_code_t ain_a1,
   input wire dacrc_pkg::dacrc_code_t ain_b0,
   input wire dacrc_pkg::dacrc_code_t ain_b1,
   output logic busy,
   output logic hold,
   output dacrc_pkg::dacrc_code_t data_o,
   output logic data_oe,
   output logic clk_lost,
   output logic start_ignored
);
   import dacrc_pkg::*;

   localparam int FW = 2 * CODE_W + 1;

   // pin synchronisers and edge memory
   logic [`DACRC_SY_W-1:0] sy1_q;
   logic [`DACRC_SY_W-1:0] sy2_q;
   logic [`DACRC_SY_W-1:0] prev_q;
   // analog front-end codes, synchronised alongside the strobes
   logic [4*CODE_W-1:0] ain1_q;
   logic [4*CODE_W-1:0] ain2_q;

   logic clk_s;
   logic start_s;
   logic pair_s;
   logic cs_s;
   logic rd_s;
   logic clk_rise;
   logic start_fall;
   logic rd_rise;
   logic pair_chg;

   // held samples of all four inputs
   dacrc_code_t hold_a0_q;
   dacrc_code_t hold_a1_q;
   dacrc_code_t hold_b0_q;
   dacrc_code_t hold_b1_q;

   // sequencer handshake
   logic conv_busy;
   logic conv_hold;
   logic conv_pair;
   logic done_valid;
   logic done_ready;
   logic [FW-1:0] done_word;

   // result buffer drain side
   logic buf_valid;
   logic buf_ready;
   logic [FW-1:0] buf_word;
   logic store;

   // latest results per pair, index is the pair
   dacrc_code_t res_a_q [2];
   dacrc_code_t res_b_q [2];
   logic ptr_q;
   logic [7:0] lost_cnt_q;

   // offset binary from the front end into two's complement
   function automatic dacrc_code_t to_twos(input dacrc_code_t raw);
      to_twos = raw ^ `DACRC_SIGN_FLIP; // RL2
   endfunction

   // select low picks input 0 of a converter, high picks input 1
   function automatic dacrc_code_t pick(input logic sel,
                                        input dacrc_code_t in0,
                                        input dacrc_code_t in1);
      pick = sel ? in1 : in0; // RL19
   endfunction

   // two flops on every pin before any logic looks at it
   always_ff @(posedge mclk) begin
      if (srst) begin
         sy1_q <= `DACRC_SY_IDLE;
         sy2_q <= `DACRC_SY_IDLE;
      end else begin
         sy1_q <= {rd_n, cs_n, channel_pair_select, conversion_start_n,
                   conv_clk};
         sy2_q <= sy1_q;
      end
   end

   // front-end codes travel with the start strobe, same latency
   always_ff @(posedge mclk) begin
      if (srst) begin
         ain1_q <= '0;
         ain2_q <= '0;
      end else begin
         ain1_q <= {ain_b1, ain_b0, ain_a1, ain_a0};
         ain2_q <= ain1_q;
      end
   end

   // previous synchronised levels for edge detection
   always_ff @(posedge mclk) begin
      if (srst) begin
         prev_q <= `DACRC_SY_IDLE;
      end else begin
         prev_q <= sy2_q;
      end
   end

   assign clk_s = sy2_q[`DACRC_SY_CLK];
   assign start_s = sy2_q[`DACRC_SY_START];
   assign pair_s = sy2_q[`DACRC_SY_PAIR];
   assign cs_s = sy2_q[`DACRC_SY_CS];
   assign rd_s = sy2_q[`DACRC_SY_RD];

   // edges of the converter clock pace the conversion
   assign clk_rise = clk_s && !prev_q[`DACRC_SY_CLK]; // RL1
   assign start_fall = !start_s && prev_q[`DACRC_SY_START];
   // end of a read strobe low; chip select is not consulted
   assign rd_rise = rd_s && !prev_q[`DACRC_SY_RD]; // RL16
   assign pair_chg = pair_s != prev_q[`DACRC_SY_PAIR];

   // all four inputs frozen on the same start fall
   always_ff @(posedge mclk) begin
      if (srst) begin
         hold_a0_q <= '0;
         hold_a1_q <= '0;
         hold_b0_q <= '0;
         hold_b1_q <= '0;
      end else if (start_fall && !conv_busy) begin
         hold_a0_q <= ain2_q[CODE_W-1:0]; // RL5
         hold_a1_q <= ain2_q[2*CODE_W-1:CODE_W]; // RL5
         hold_b0_q <= ain2_q[3*CODE_W-1:2*CODE_W]; // RL5
         hold_b1_q <= ain2_q[4*CODE_W-1:3*CODE_W]; // RL5
      end
   end

   // sixteen converter cycles per conversion
   dacrc_conv #(
      .CONV_CYCLES(`DACRC_CONV_CYCLES)
   ) u_conv (
      .mclk(mclk),
      .srst(srst),
      .start_fall(start_fall),
      .clk_rise(clk_rise),
      .pair_level(pair_s),
      .busy(conv_busy),
      .holding(conv_hold),
      .pair_latched(conv_pair),
      .done_valid(done_valid),
      .done_ready(done_ready)
   );

   // result word: pair, first converter, second converter
   assign done_word = {conv_pair,
                       to_twos(pick(conv_pair, hold_a0_q, hold_a1_q)),
                       to_twos(pick(conv_pair, hold_b0_q, hold_b1_q))};

   // a full buffer keeps the sequencer busy, so a start in that time is dropped
   dacrc_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .srst(srst),
      .in_valid(done_valid),
      .in_ready(done_ready),
      .in_data(done_word),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_word)
   );

   // drain only while no read strobe is low, so a read never tears
   assign buf_ready = rd_s && prev_q[`DACRC_SY_RD];
   assign store = buf_valid && buf_ready;

   // latest result of each pair stays readable during later conversions
   always_ff @(posedge mclk) begin
      if (srst) begin
         res_a_q[0] <= '0;
         res_a_q[1] <= '0;
         res_b_q[0] <= '0;
         res_b_q[1] <= '0;
      end else if (store) begin
         res_a_q[buf_word[FW-1]] <= buf_word[2*CODE_W-1:CODE_W]; // RL12
         res_b_q[buf_word[FW-1]] <= buf_word[CODE_W-1:0]; // RL12
      end
   end

   // read pointer; a return to the first converter beats an advance
   always_ff @(posedge mclk) begin
      if (srst) begin
         ptr_q <= 1'b0;
      end else if (pair_chg || store) begin
         ptr_q <= 1'b0; // RL20
      end else if (rd_rise) begin
         ptr_q <= !ptr_q; // RL16
      end
   end

   // bus value: current pair, first or second converter by pointer
   always_ff @(posedge mclk) begin
      if (srst) begin
         data_o <= '0;
      end else if (ptr_q) begin
         data_o <= res_b_q[pair_s]; // RL11
      end else begin
         data_o <= res_a_q[pair_s]; // RL13
      end
   end

   // drive the bus only while both strobes are low; msb sits on bit 11
   always_ff @(posedge mclk) begin
      if (srst) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= !cs_s && !rd_s; // RL10 RL18
      end
   end

   // busy and hold mirror the sequencer, registered for clean pins
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy <= 1'b0;
         hold <= 1'b0;
      end else begin
         busy <= conv_busy || start_fall; // RL9
         hold <= conv_hold || start_fall; // RL5
      end
   end

   // start strobes landing on a running conversion are dropped
   always_ff @(posedge mclk) begin
      if (srst) begin
         start_ignored <= 1'b0;
      end else begin
         start_ignored <= start_fall && conv_busy;
      end
   end

   // watchdog on the converter clock; slowest legal period is 5 us
   always_ff @(posedge mclk) begin
      if (srst) begin
         lost_cnt_q <= 8'h0;
         clk_lost <= 1'b0;
      end else if (clk_rise) begin
         lost_cnt_q <= 8'h0;
         clk_lost <= 1'b0;
      end else if (lost_cnt_q == 8'(CLK_LOST_CYC)) begin
         clk_lost <= 1'b1;
      end else begin
         lost_cnt_q <= lost_cnt_q + 8'h1;
      end
   end
endmodule // dacrc_top

// file: include/dacrc_map.svh
`ifndef DACRC_MAP_SVH
`define DACRC_MAP_SVH

// system clock rate
`define DACRC_MCLK_HZ 25000000
// result width and conversion length in converter clock cycles
`define DACRC_CODE_W 12
`define DACRC_CONV_CYCLES 16
// nominal converter clock and resulting sample rate per converter
`define DACRC_CONV_CLK_HZ 8000000
`define DACRC_SAMPLE_HZ 500000
// longest converter clock period, and its count in system cycles
`define DACRC_CLK_PERIOD_MAX_NS 5000
`define DACRC_CLK_LOST_CYC \
   ((`DACRC_CLK_PERIOD_MAX_NS * (`DACRC_MCLK_HZ / 1000000)) / 1000)
// result buffer depth
`define DACRC_FIFO_DEPTH 8
// pin synchroniser bit positions
`define DACRC_SY_CLK 0
`define DACRC_SY_START 1
`define DACRC_SY_PAIR 2
`define DACRC_SY_CS 3
`define DACRC_SY_RD 4
`define DACRC_SY_W 5
// idle levels of the synchronised pins: strobes high, clock and select low
`define DACRC_SY_IDLE 5'h1a
// offset binary to two's complement: invert the sign bit
`define DACRC_SIGN_FLIP 12'h800

`endif

// file: include/dacrc_pkg.sv
package dacrc_pkg;
   // conversion sequencer states
   typedef enum logic [1:0] {
      CV_IDLE,
      CV_ARM,
      CV_RUN,
      CV_PUSH
   } dacrc_conv_state_t;
   typedef logic [11:0] dacrc_code_t;
endpackage

// file: design/dacrc_fifo.sv
`include "dacrc_map.svh"

module dacrc_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = `DACRC_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   // extra pointer bit tells full from empty
   assign in_ready = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = wr_q != rd_q;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_q[AW-1:0]];

   // storage
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule // dacrc_fifo

// file: design/dacrc_conv.sv
`include "dacrc_map.svh"

module dacrc_conv #(
   parameter int CONV_CYCLES = `DACRC_CONV_CYCLES
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic start_fall,
   input wire logic clk_rise,
   input wire logic pair_level,
   output logic busy,
   output logic holding,
   output logic pair_latched,
   output logic done_valid,
   input wire logic done_ready
);
   import dacrc_pkg::*;

   dacrc_conv_state_t state_q;
   logic [4:0] cnt_q;
   logic pair_q;

   assign busy = state_q != CV_IDLE;
   assign holding = state_q != CV_IDLE;
   assign pair_latched = pair_q;
   assign done_valid = state_q == CV_PUSH;

   // sequencer; a start during a conversion is ignored
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_q <= CV_IDLE;
      end else begin
         unique case (state_q)
            CV_IDLE: if (start_fall) state_q <= CV_ARM; // RL9
            CV_ARM: if (clk_rise) state_q <= CV_RUN; // RL6
            CV_RUN: begin
               // last of the sixteen converter cycles ends the conversion
               if (clk_rise && cnt_q == 5'(CONV_CYCLES)) begin
                  state_q <= CV_PUSH; // RL6
               end
            end
            // busy holds until the buffer takes the result
            CV_PUSH: if (done_ready) state_q <= CV_IDLE; // RL9
         endcase
      end
   end

   // converter cycle count; the starting edge is cycle one
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_q <= 5'h0;
      end else if (state_q == CV_ARM && clk_rise) begin
         cnt_q <= 5'h2; // RL6
      end else if (state_q == CV_RUN && clk_rise) begin
         cnt_q <= cnt_q + 5'h1;
      end
   end

   // pair chosen at the edge that starts converting
   always_ff @(posedge mclk) begin
      if (srst) begin
         pair_q <= 1'b0;
      end else if (state_q == CV_ARM && clk_rise) begin
         pair_q <= pair_level; // RL7
      end
   end
endmodule // dacrc_conv

// file: bench/dacrc_top_monitor.sv
module dacrc_top_monitor #(
   parameter int CODE_W = 12,
   parameter int FIFO_DEPTH = 8,
   parameter int CLK_LOST_CYC = 125
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic conv_clk,
   input wire logic conversion_start_n,
   input wire logic channel_pair_select,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic busy,
   input wire logic hold,
   input wire logic data_oe,
   input wire logic start_ignored
);
   timeunit 1ns;
   timeprecision 100ps;
   logic cc_q;
   logic [4:0] rise_cnt_q;
   logic rd_sel;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // both bus strobes low at the pins
   assign rd_sel = !cs_n && !rd_n;
   // raw clock rises while busy; sync lag hides at most one
   always_ff @(posedge mclk) begin
      cc_q <= conv_clk;
      if (srst || !busy) begin
         rise_cnt_q <= 5'h00;
      end else if (conv_clk && !cc_q) begin
         rise_cnt_q <= rise_cnt_q + 5'h01;
      end
   end
   bus_gate_a: assert property (data_oe |-> $past(rd_sel, 3))
      else $error("bus driven without select and read");
   bus_on_a: assert property (rd_sel [*5] |-> data_oe)
      else $error("bus not driven during read");
   bus_off_a: assert property ($rose(rd_n) |-> ##3 !data_oe)
      else $error("bus not released after read");
   busy_go_a: assert property
      (!busy && $fell(conversion_start_n) |-> ##[2:4] busy)
      else $error("busy late after start");
   hold_busy_a: assert property (hold == busy)
      else $error("hold and busy disagree");
   conv_len_a: assert property
      ($fell(busy) |-> rise_cnt_q inside {[15:16]})
      else $error("conversion length wrong");
   ignore_busy_a: assert property (start_ignored |-> $past(busy))
      else $error("start dropped while idle");
   rst_idle_a: assert property (disable iff (1'b0)
      srst |=> !busy && !hold && !data_oe)
      else $error("outputs active after reset");
   cover property ($fell(busy));
   cover property ($rose(data_oe) && channel_pair_select);
   cover property (start_ignored);
endmodule // dacrc_top_monitor

bind dacrc_top dacrc_top_monitor #(
   .CODE_W(CODE_W), .FIFO_DEPTH(FIFO_DEPTH), .CLK_LOST_CYC(CLK_LOST_CYC)
) i_mon (.mclk, .srst, .conv_clk, .conversion_start_n,
   .channel_pair_select, .cs_n, .rd_n, .busy, .hold, .data_oe,
   .start_ignored);

// file: bench/dacrc_host.sv
module dacrc_host (
   input wire logic mclk,
   input wire logic busy,
   input wire logic data_oe,
   input wire dacrc_pkg::dacrc_code_t data_o,
   output logic conversion_start_n,
   output logic channel_pair_select,
   output logic cs_n,
   output logic rd_n
);
   timeunit 1ns;
   timeprecision 100ps;
   import dacrc_pkg::*;
   // strobes idle high until asked
   initial begin
      conversion_start_n = 1'b1;
      channel_pair_select = 1'b0;
      cs_n = 1'b1;
      rd_n = 1'b1;
   end
   // act just after the edge, so no race with the design
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // eight cycles of setup, well over the minimum
   task automatic select(input logic s);
      channel_pair_select = s;
      step(8);
   endtask
   task automatic strobe();
      conversion_start_n = 1'b0;
      step(4);
      conversion_start_n = 1'b1;
      step(1);
   endtask
   // start, then bounded wait for busy to drop
   task automatic convert(output bit ok);
      int i;
      strobe();
      ok = 1'b0;
      for (i = 0; i < 300 && !ok; i++) begin
         step(1);
         ok = busy === 1'b0;
      end
      step(4);
   endtask
   // unselected reads still toggle the read strobe, with chip select held high
   task automatic read(input logic sel_dev, output dacrc_code_t d,
      output bit ok);
      int i;
      cs_n = !sel_dev;
      rd_n = 1'b0;
      ok = !sel_dev;
      for (i = 0; i < 10 && !ok; i++) begin
         step(1);
         ok = data_oe === 1'b1;
      end
      d = data_o;
      step(4);
      rd_n = 1'b1;
      step(4);
      cs_n = 1'b1;
      step(1);
   endtask
endmodule // dacrc_host

// file: bench/dacrc_bench.sv
`define CHK(got, exp) begin \
   n_tests++; \
   if ((got) !== (exp)) begin \
      err_count++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); \
   end \
end

module dacrc_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import dacrc_pkg::*;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic conv_clk = 1'b0;
   logic conversion_start_n, channel_pair_select, cs_n, rd_n;
   logic busy, hold, data_oe, clk_lost, start_ignored;
   bit clk_run = 1'b1;
   int n_ign = 0;
   logic sel = 1'b0;
   dacrc_code_t ain_a0 = 12'h000, ain_a1 = 12'h000;
   dacrc_code_t ain_b0 = 12'h000, ain_b1 = 12'h000;
   dacrc_code_t data_o;
   dacrc_code_t res [2][2] = '{default: 12'h000};
   dacrc_code_t tbl [4] = '{12'hfff, 12'h800, 12'h7ff, 12'h000};
   int err_count = 0, n_tests = 0, ptr = 0, k;
   // system clock; converter clock free running at seven system periods, rising 1 ns after a system rise
   initial forever #20 mclk = ~mclk;
   // kept off the system edges so the pin syncs never race; clk_run stops it
   initial begin
      #1;
      forever #140 conv_clk = ~conv_clk & clk_run;
   end
   dacrc_top i_dut (.mclk(mclk), .srst(srst), .conv_clk(conv_clk),
      .conversion_start_n(conversion_start_n),
      .channel_pair_select(channel_pair_select), .cs_n(cs_n),
      .rd_n(rd_n), .ain_a0(ain_a0), .ain_a1(ain_a1), .ain_b0(ain_b0),
      .ain_b1(ain_b1), .busy(busy), .hold(hold), .data_o(data_o),
      .data_oe(data_oe), .clk_lost(clk_lost),
      .start_ignored(start_ignored));
   dacrc_host i_host (.mclk(mclk), .busy(busy), .data_oe(data_oe),
      .data_o(data_o), .conversion_start_n(conversion_start_n),
      .channel_pair_select(channel_pair_select), .cs_n(cs_n),
      .rd_n(rd_n));
   // dropped starts, counted from the one-cycle pulse
   always @(posedge mclk) begin
      if (start_ignored === 1'b1) n_ign++;
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic timeout();
      err_count++;
      print_verdict();
   endtask
   // a pair change sends the read pointer home
   task automatic set_sel(input logic s);
      if (s !== sel) ptr = 0;
      sel = s;
      i_host.select(s);
   endtask
   task automatic conv(input logic s);
      bit ok;
      set_sel(s);
      i_host.convert(ok);
      if (!ok) timeout();
      res[s][0] = (s ? ain_a1 : ain_a0) ^ 12'h800;
      res[s][1] = (s ? ain_b1 : ain_b0) ^ 12'h800;
      ptr = 0;
   endtask
   // every strobe toggle moves the pointer, selected or not
   task automatic rd(input logic cs);
      bit ok;
      dacrc_code_t d;
      i_host.read(cs, d, ok);
      if (!ok) timeout();
      if (cs) `CHK(d, res[sel][ptr])
      ptr = 1 - ptr;
   endtask
   task automatic rnd();
      ain_a0 = dacrc_code_t'($urandom);
      ain_a1 = dacrc_code_t'($urandom);
      ain_b0 = dacrc_code_t'($urandom);
      ain_b1 = dacrc_code_t'($urandom);
   endtask
   initial begin
      void'($urandom(83264));
      i_host.step(3);
      srst = 1'b0;
      `CHK(busy, 1'b0)
      `CHK(data_oe, 1'b0)
      rd(1'b1);
      // edge codes of the output format, three reads each
      for (k = 0; k < 4; k++) begin
         ain_a0 = tbl[k];
         ain_b0 = tbl[3 - k];
         conv(1'b0);
         repeat (3) rd(1'b1);
      end
      rnd();
      conv(1'b1);
      rnd();
      conv(1'b0);
      rd(1'b1);
      set_sel(1'b1);
      rd(1'b0);
      rd(1'b1);
      set_sel(1'b0);
      rd(1'b1);
      rd(1'b1);
      // old results read while the next conversion runs
      rnd();
      fork
         conv(1'b0);
         begin
            i_host.step(30);
            set_sel(1'b1);
            rd(1'b1);
            rd(1'b1);
            i_host.strobe(); // late start must be ignored
         end
      join
      `CHK(n_ign, 1)
      set_sel(1'b0);
      rd(1'b1);
      rd(1'b1);
      `CHK(clk_lost, 1'b0)
      // converter clock stopped: the watchdog must notice
      clk_run = 1'b0;
      i_host.step(140);
      `CHK(clk_lost, 1'b1)
      print_verdict();
   end
endmodule // dacrc_bench
